/* File: rtl/etc_defines.vh */
/*
 constants for the eight bit timer counter: register offsets, field
 positions, reset values and mode codes. assumes inclusion by bare name.
*/
`ifndef ETC_DEFINES_VH
`define ETC_DEFINES_VH
`define ETC_OFF_CTRL 8'h54
`define ETC_OFF_CMP 8'h64
`define ETC_OFF_STAT 8'h00
`define ETC_OFF_MASK 8'h04
`define ETC_OFF_CNT 8'h08
`define ETC_OFF_PSC 8'h0c
`define ETC_IDX_CTRL 8'h15
`define ETC_IDX_CMP 8'h19
`define ETC_CTRL_RST 8'h00
`define ETC_CMP_RST 8'hff
`define ETC_RUN_BIT 5
`define ETC_CK_LSB 2
`define ETC_MODE_LSB 0
`define ETC_MODE_TMR 2'h0
`define ETC_MODE_PDO 2'h2
`define ETC_MODE_PWM 2'h3
`define ETC_CK_EXT 3'h7
`define ETC_RESP_OK 2'h0
`define ETC_RESP_ERR 2'h2
`endif

/* File: rtl/etc_tick.v */
/*
 prescaled tick generator: picks one tap of a free running divider.
 assumes high and low clock enables are one-cycle pulses on ref_clk.
*/
`timescale 1ns/1ps
module etc_tick (
    input wire clk,
    input wire rst_n,
    input wire hf_tick,
    input wire lf_tick,
    input wire [2:0] ck_sel,
    input wire stage_sel,
    input wire low_src_sel,
    input wire low_speed,
    output reg tick_ff
);
    reg [12:0] hdiv_ff;
    reg [2:0] ldiv_ff;
    reg [3:0] shift;
    reg nxt_tick;
    wire [13:0] hnext = {1'b0, hdiv_ff} + 14'h0001;
    // a tap of divisor 2^n fires when the low n bits wrap
    function tap;
        input [12:0] cnt;
        input [3:0] n;
        reg [12:0] m;
        begin
            m = (13'h0001 << n) - 13'h0001;
            tap = ((cnt & m) == m);
        end
    endfunction
    always @* begin
        shift = 4'h0;
        case (ck_sel)
            3'h1: shift = 4'h7;
            3'h2: shift = 4'h5;
            3'h3: shift = 4'h3;
            3'h4: shift = 4'h2;
            3'h5: shift = 4'h1;
            default: shift = 4'h0;
        endcase
        nxt_tick = 1'b0;
        if (ck_sel == 3'h0) begin
            if (low_src_sel || low_speed) begin
                nxt_tick = lf_tick && (ldiv_ff == 3'h7);
            end else begin
                nxt_tick = hf_tick &&
                    tap(hdiv_ff, stage_sel ? 4'hc : 4'hb);
            end
        end else if (ck_sel != 3'h7 && !low_speed) begin
            nxt_tick = hf_tick &&
                tap(hdiv_ff, shift + {3'h0, stage_sel});
        end
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hdiv_ff <= 13'h0000;
            ldiv_ff <= 3'h0;
            tick_ff <= 1'b0;
        end else begin
            if (hf_tick) begin
                hdiv_ff <= hnext[12:0];
            end
            if (lf_tick) begin
                ldiv_ff <= ldiv_ff + 3'h1;
            end
            tick_ff <= nxt_tick;
        end
    end
endmodule

/* File: rtl/etc_sync.v */
/*
 two flop synchroniser with edge detect for the event pin.
 assumes the pin level may change at any time.
*/
`timescale 1ns/1ps
module etc_sync (
    input wire clk,
    input wire rst_n,
    input wire din,
    output wire rise,
    output wire fall
);
    reg s1_ff;
    reg s2_ff;
    reg s3_ff;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
    assign rise = s2_ff && !s3_ff;
    assign fall = !s2_ff && s3_ff;
endmodule

/* File: rtl/etc_timer.v */
/*
 eight bit timer counter top with axi4-lite register slave.
 assumes one clock, asynchronous active low reset, prescaler enables
 and power mode levels from the system controller.
*/
// Contract
// - run bit zero stops and clears counter; one starts counting.
// - code 000 picks hf/2^11 or 2^12, or lf/2^3.
// - codes 001-110 pick hf/128..1, doubled by stage select; the code gives no tick on these codes while LOW_SPEED is high.
// - code 111 counts the external event pin.
// - mode 00 timer/event, 10 divider, 11 pwm, 01 reserved.
// - stop power mode entry clears the run bit.
// - control bits 7 and 6 read as don't care.
// - timer mode match raises interrupt and clears counter.
// - event mode counts rises, match seen at following fall.
// - divider match toggles pin; pin high when stopped.
// - pwm low at match, high at overflow; shadow loads at end.
`timescale 1ns/1ps
`include "etc_defines.vh"
module etc_timer (
    input wire REF_CLK,
    input wire RST_N,
    input wire HF_TICK,
    input wire LF_TICK,
    input wire LOW_SPEED,
    input wire STOP_ENTRY,
    input wire EVENT_IN,
    output reg DIVIDER_OUT,
    output reg PWM_OUT,
    output reg IRQ,
    input wire [7:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output reg S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output reg S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [7:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output reg S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY
);
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_RESP = 3'b100;
    reg [7:0] ctrl_ff;
    reg [7:0] cmp_ff;
    reg [7:0] shadow_ff;
    reg [7:0] cnt_ff;
    reg [1:0] stat_ff;
    reg [1:0] mask_ff;
    reg [2:0] wst_ff;
    reg [7:0] awaddr_ff;
    reg aw_got_ff;
    reg [31:0] wdata_ff;
    reg w_got_ff;
    reg hit_ff;
    reg [7:0] nxt_cnt;
    reg nxt_match;
    reg nxt_ovf;
    reg [31:0] nxt_rdata;
    reg [1:0] nxt_rresp;
    wire tick;
    wire ev_rise;
    wire ev_fall;
    wire run = ctrl_ff[`ETC_RUN_BIT];
    wire [2:0] ck_sel = ctrl_ff[`ETC_CK_LSB+2:`ETC_CK_LSB];
    wire [1:0] mode = ctrl_ff[`ETC_MODE_LSB+1:`ETC_MODE_LSB];
    wire ext = (ck_sel == `ETC_CK_EXT);
    wire step = ext ? ev_rise : tick;
    wire [7:0] cmp_use = (mode == `ETC_MODE_PWM) ? shadow_ff : cmp_ff;
    // prescaler selects live in their own register at the psc offset
    reg [1:0] psel_ff;
    wire wr_fire = aw_got_ff && w_got_ff && (wst_ff == ST_WAIT);
    // a write with its low byte lane off leaves every register alone
    reg wstrb0_ff;
    wire wr_ctrl = wr_fire && awaddr_ff == `ETC_OFF_CTRL && wstrb0_ff;
    wire wr_cmp = wr_fire && awaddr_ff == `ETC_OFF_CMP && wstrb0_ff;
    wire wr_stat = wr_fire && awaddr_ff == `ETC_OFF_STAT && wstrb0_ff;
    wire wr_mask = wr_fire && awaddr_ff == `ETC_OFF_MASK && wstrb0_ff;
    wire wr_psc = wr_fire && awaddr_ff == `ETC_OFF_PSC && wstrb0_ff;
    wire start = wr_ctrl && !run && wdata_ff[`ETC_RUN_BIT];
    etc_tick u_tick (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .hf_tick(HF_TICK),
        .lf_tick(LF_TICK),
        .ck_sel(ck_sel),
        .stage_sel(psel_ff[0]),
        .low_src_sel(psel_ff[1]),
        .low_speed(LOW_SPEED),
        .tick_ff(tick)
    );
    etc_sync u_sync (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .din(EVENT_IN),
        .rise(ev_rise),
        .fall(ev_fall)
    );
    ////////////////////////////////////////////////////////////////////////
    // counting core; a match in event mode waits for the pin to fall
    always @* begin
        nxt_cnt = cnt_ff;
        nxt_match = 1'b0;
        nxt_ovf = 1'b0;
        if (!run) begin
            nxt_cnt = 8'h00;
        end else if (mode == `ETC_MODE_PWM) begin
            if (step) begin
                nxt_cnt = cnt_ff + 8'h01;
                nxt_ovf = (cnt_ff == 8'hff);
                nxt_match = (cnt_ff + 8'h01 == cmp_use);
            end
        end else if (ext) begin
            if (ev_fall && hit_ff) begin
                nxt_cnt = 8'h00;
                nxt_match = 1'b1;
            end else if (step) begin
                nxt_cnt = cnt_ff + 8'h01;
            end
        end else if (step) begin
            if (cnt_ff + 8'h01 == cmp_use) begin
                nxt_cnt = 8'h00;
                nxt_match = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 8'h01;
            end
        end
    end
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_ff <= 8'h00;
            hit_ff <= 1'b0;
            shadow_ff <= `ETC_CMP_RST;
            DIVIDER_OUT <= 1'b1;
            PWM_OUT <= 1'b1;
            stat_ff <= 2'h0;
            IRQ <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            hit_ff <= run && ext && (nxt_cnt == cmp_ff);
            if (start || (run && nxt_ovf)) begin
                shadow_ff <= cmp_ff;
            end
            if (!run || mode != `ETC_MODE_PDO) begin
                DIVIDER_OUT <= 1'b1;
            end else if (nxt_match) begin
                DIVIDER_OUT <= !DIVIDER_OUT;
            end
            if (!run || mode != `ETC_MODE_PWM) begin
                PWM_OUT <= 1'b1;
            end else if (nxt_ovf) begin
                PWM_OUT <= 1'b1;
            end else if (nxt_match) begin
                PWM_OUT <= 1'b0;
            end
            // set wins over a same-cycle write-one clear
            stat_ff[0] <= (nxt_match && mode != `ETC_MODE_PWM) ||
                (stat_ff[0] && !(wr_stat && wdata_ff[0]));
            stat_ff[1] <= nxt_ovf ||
                (stat_ff[1] && !(wr_stat && wdata_ff[1]));
            IRQ <= |(stat_ff & mask_ff);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wst_ff <= ST_IDLE;
            awaddr_ff <= 8'h00;
            aw_got_ff <= 1'b0;
            wdata_ff <= 32'h00000000;
            w_got_ff <= 1'b0;
            wstrb0_ff <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `ETC_RESP_OK;
            ctrl_ff <= `ETC_CTRL_RST;
            cmp_ff <= `ETC_CMP_RST;
            mask_ff <= 2'h0;
            psel_ff <= 2'h0;
        end else begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            case (wst_ff)
                ST_IDLE: begin
                    aw_got_ff <= 1'b0;
                    w_got_ff <= 1'b0;
                    wst_ff <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (S_AXI_AWVALID && !aw_got_ff && !S_AXI_AWREADY) begin
                        S_AXI_AWREADY <= 1'b1;
                    end
                    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                        awaddr_ff <= S_AXI_AWADDR;
                        aw_got_ff <= 1'b1;
                    end
                    if (S_AXI_WVALID && !w_got_ff && !S_AXI_WREADY) begin
                        S_AXI_WREADY <= 1'b1;
                    end
                    if (S_AXI_WVALID && S_AXI_WREADY) begin
                        wdata_ff <= S_AXI_WDATA;
                        w_got_ff <= 1'b1;
                        wstrb0_ff <= S_AXI_WSTRB[0];
                    end
                    if (wr_fire) begin
                        S_AXI_BVALID <= 1'b1;
                        S_AXI_BRESP <= `ETC_RESP_OK;
                        if (awaddr_ff != `ETC_OFF_CTRL &&
                            awaddr_ff != `ETC_OFF_CMP &&
                            awaddr_ff != `ETC_OFF_STAT &&
                            awaddr_ff != `ETC_OFF_MASK &&
                            awaddr_ff != `ETC_OFF_PSC) begin
                            S_AXI_BRESP <= `ETC_RESP_ERR;
                        end
                        wst_ff <= ST_RESP;
                    end
                end
                ST_RESP: begin
                    if (S_AXI_BREADY) begin
                        S_AXI_BVALID <= 1'b0;
                        wst_ff <= ST_IDLE;
                    end
                end
                default: wst_ff <= ST_IDLE;
            endcase
            if (STOP_ENTRY) begin
                ctrl_ff[`ETC_RUN_BIT] <= 1'b0;
            end else if (wr_ctrl) begin
                ctrl_ff <= {2'h0, wdata_ff[5:0]};
            end
            if (wr_cmp) begin
                cmp_ff <= wdata_ff[7:0];
            end
            if (wr_mask) begin
                mask_ff <= wdata_ff[1:0];
            end
            if (wr_psc) begin
                psel_ff <= wdata_ff[1:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel, one cycle after the address
    always @* begin
        nxt_rdata = 32'h00000000;
        nxt_rresp = `ETC_RESP_OK;
        if (S_AXI_ARADDR == `ETC_OFF_CTRL) begin
            nxt_rdata = {24'h000000, 2'h0, ctrl_ff[5:0]};
        end else if (S_AXI_ARADDR == `ETC_OFF_CMP) begin
            nxt_rdata = {24'h000000, cmp_ff};
        end else if (S_AXI_ARADDR == `ETC_OFF_STAT) begin
            nxt_rdata = {30'h00000000, stat_ff};
        end else if (S_AXI_ARADDR == `ETC_OFF_MASK) begin
            nxt_rdata = {30'h00000000, mask_ff};
        end else if (S_AXI_ARADDR == `ETC_OFF_CNT) begin
            nxt_rdata = {24'h000000, cnt_ff};
        end else if (S_AXI_ARADDR == `ETC_OFF_PSC) begin
            nxt_rdata = {30'h00000000, psel_ff};
        end else begin
            nxt_rresp = `ETC_RESP_ERR;
        end
    end
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= `ETC_RESP_OK;
        end else begin
            S_AXI_ARREADY <= 1'b0;
            if (S_AXI_RVALID) begin
                if (S_AXI_RREADY) begin
                    S_AXI_RVALID <= 1'b0;
                end
            end else if (S_AXI_ARVALID && !S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b1;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= nxt_rdata;
                S_AXI_RRESP <= nxt_rresp;
            end
        end
    end
endmodule

/* File: verification/etc_timer_monitor.sv */
/*
 port checker for etc_timer: idle pin levels and bus answers.
 assumes the ports of etc_timer and its one clock domain.
*/
`timescale 1ns/1ps
module etc_timer_monitor (
    input wire REF_CLK,
    input wire RST_N,
    input wire STOP_ENTRY,
    input wire DIVIDER_OUT,
    input wire PWM_OUT,
    input wire IRQ,
    input wire [7:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    input wire S_AXI_AWREADY,
    input wire [1:0] S_AXI_BRESP,
    input wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [7:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    input wire S_AXI_ARREADY,
    input wire [31:0] S_AXI_RDATA,
    input wire [1:0] S_AXI_RRESP,
    input wire S_AXI_RVALID,
    input wire S_AXI_RREADY
);
    function automatic bit mapped(input logic [7:0] a);
        return a inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h54, 8'h64};
    endfunction
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    ////////////////////////////////
    idle_pins_a: assert property (
        $rose(RST_N) |-> DIVIDER_OUT && PWM_OUT && !IRQ)
        else $error("pins not idle after reset");
    stop_pins_a: assert property (
        STOP_ENTRY |-> ##[1:4] (DIVIDER_OUT && PWM_OUT))
        else $error("pins not high after stop entry");
    ctrl_upper_a: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'h54
        |-> S_AXI_RVALID && S_AXI_RDATA[31:6] == 26'h0)
        else $error("control upper bits not zero");
    bad_read_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY
        && !mapped(S_AXI_ARADDR) |-> S_AXI_RRESP == 2'h2)
        else $error("unmapped read not refused");
    bad_write_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY
        && !mapped(S_AXI_AWADDR)
        |-> ##[1:4] (S_AXI_BVALID && S_AXI_BRESP == 2'h2))
        else $error("unmapped write not refused");
    b_answer_a: assert property (
        S_AXI_AWVALID && S_AXI_AWREADY |-> ##[1:4] S_AXI_BVALID)
        else $error("write response late");
    b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY
        |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
        |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped");
endmodule
bind etc_timer etc_timer_monitor u_etc_timer_monitor (.REF_CLK, .RST_N,
    .STOP_ENTRY, .DIVIDER_OUT, .PWM_OUT, .IRQ, .S_AXI_AWADDR,
    .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
    .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);

/* File: verification/etc_timer_bench.sv */
/*
 self-checking bench for etc_timer: registers, clock taps, modes, irq.
 assumes the high clock enable runs every cycle and stands for a high
 clock of 50 MHz; lf pulses every 4.
*/
`timescale 1ns/1ps
module etc_timer_bench;
    logic REF_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic HF_TICK = 1'b1;
    logic LF_TICK = 1'b0;
    logic LOW_SPEED = 1'b0;
    logic STOP_ENTRY = 1'b0;
    logic EVENT_IN = 1'b0;
    logic [7:0] S_AXI_AWADDR = 8'h0;
    logic S_AXI_AWVALID = 1'b0;
    logic [31:0] S_AXI_WDATA = 32'h0;
    logic [3:0] S_AXI_WSTRB = 4'hf;
    logic S_AXI_WVALID = 1'b0;
    logic S_AXI_BREADY = 1'b0;
    logic [7:0] S_AXI_ARADDR = 8'h0;
    logic S_AXI_ARVALID = 1'b0;
    logic S_AXI_RREADY = 1'b0;
    logic DIVIDER_OUT, PWM_OUT, IRQ, S_AXI_AWREADY, S_AXI_WREADY;
    logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic [31:0] S_AXI_RDATA, v, n;
    logic [1:0] lfc = 2'h0;
    int miscompares = 0;
    int n_tests = 0;
    int i, c, c2, st, d, cf;
    always #10 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK) begin
        lfc <= lfc + 2'h1;
        LF_TICK <= (lfc == 2'h3);
    end
    etc_timer u_etc_timer (.REF_CLK, .RST_N, .HF_TICK, .LF_TICK,
        .LOW_SPEED, .STOP_ENTRY, .EVENT_IN, .DIVIDER_OUT, .PWM_OUT, .IRQ,
        .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
        .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
        .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
        .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
        .S_AXI_RREADY);
    ////////////////////////////////
    task automatic results;
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tmo;
        chk(32'h0, 32'h1);
        results();
    endtask
    // stalls bready at random so a held response is seen too
    task automatic wr(input logic [7:0] a, input logic [31:0] dt,
                      input logic [1:0] er);
        int k;
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= dt;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'($urandom % 2);
        for (k = 0; k < 40; k++) begin
            @(posedge REF_CLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
            if (S_AXI_BVALID && S_AXI_BREADY) break;
            if (S_AXI_BVALID) S_AXI_BREADY <= 1'b1;
        end
        if (k == 40) tmo();
        S_AXI_BREADY <= 1'b0;
        chk(S_AXI_BRESP, er);
        @(posedge REF_CLK);
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        int k;
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'($urandom % 2);
        for (k = 0; k < 40; k++) begin
            @(posedge REF_CLK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
            if (S_AXI_RVALID && S_AXI_RREADY) break;
            if (S_AXI_RVALID) S_AXI_RREADY <= 1'b1;
        end
        if (k == 40) tmo();
        S_AXI_RREADY <= 1'b0;
        v = S_AXI_RDATA;
        chk(S_AXI_RRESP, er);
        @(posedge REF_CLK);
    endtask
    task automatic go(input logic [7:0] cfg);
        wr(8'h54, {24'h0, cfg}, 2'h0);
        wr(8'h54, {24'h0, cfg | 8'h20}, 2'h0);
    endtask
    // cycles between a rise (or a fall) of a pin and its next rise
    task automatic span(input int sel, input bit ff, output logic [31:0] w);
        int k;
        bit seen;
        logic p;
        logic q;
        seen = 0;
        w = 0;
        p = (sel == 2) ? IRQ : sel ? PWM_OUT : DIVIDER_OUT;
        for (k = 0; k < 20000; k++) begin
            @(posedge REF_CLK);
            q = (sel == 2) ? IRQ : sel ? PWM_OUT : DIVIDER_OUT;
            w++;
            if (seen && q && !p) break;
            if (!seen && (ff ? (p && !q) : (q && !p))) begin
                seen = 1;
                w = 0;
            end
            p = q;
        end
        if (k == 20000) tmo();
    endtask
    task automatic wirq;
        int k;
        for (k = 0; k < 2000 && IRQ !== 1'b1; k++) @(posedge REF_CLK);
        if (k == 2000) tmo();
    endtask
    function automatic int dv(input int cd, input int s);
        int t[7] = '{2048, 128, 32, 8, 4, 2, 1};
        return t[cd] << s;
    endfunction
    ////////////////////////////////
    initial begin
        void'($urandom(32'h90e984dd));
        repeat (5) @(posedge REF_CLK);
        RST_N <= 1'b1;
        @(posedge REF_CLK);
        rd(8'h54, 2'h0);
        chk(v & 32'h3f, 32'h0);
        rd(8'h64, 2'h0);
        chk(v, 32'hff);
        rd(8'h40, 2'h2);
        wr(8'h40, 32'h1, 2'h2);
        $display("registers done");
        for (i = 0; i < 7; i++) begin
            st = $urandom % 2;
            c = (i < 3) ? 1 : 16 + $urandom % 200;
            cf = (i << 2) | ((i < 3) ? 2 : 3);
            d = dv(i, st);
            wr(8'h0c, st, 2'h0);
            wr(8'h64, c, 2'h0);
            go(8'(cf));
            if (i < 3) begin
                span(0, 0, n);
                chk(n, 2 * d);
            end else begin
                span(1, 0, n);
                chk(n, 256 * d);
                c2 = 16 + $urandom % 200;
                wr(8'h64, c2, 2'h0);
                span(1, 1, n);
                chk(n, (256 - c) * d);
                span(1, 1, n);
                chk(n, (256 - c2) * d);
            end
            wr(8'h54, cf, 2'h0);
            repeat (2) @(posedge REF_CLK);
            chk({DIVIDER_OUT, PWM_OUT}, 2'h3);
        end
        rd(8'h00, 2'h0);
        chk(v & 32'h2, 32'h2);
        wr(8'h64, 32'h1, 2'h0);
        for (i = 0; i < 2; i++) begin
            wr(8'h0c, i ? 32'h0 : 32'h2, 2'h0);
            LOW_SPEED <= i[0];
            go(8'h02);
            span(0, 0, n);
            chk(n, 32'd64);
            wr(8'h54, 32'h2, 2'h0);
        end
        LOW_SPEED <= 1'b0;
        $display("clock taps done");
        c = 3 + $urandom % 20;
        wr(8'h64, c, 2'h0);
        wr(8'h0c, 32'h0, 2'h0);
        wr(8'h04, 32'h1, 2'h0);
        wr(8'h00, 32'h3, 2'h0);
        go(8'h0c);
        fork
            span(2, 0, n);
            begin
                wirq();
                wr(8'h00, 32'h1, 2'h0);
            end
        join
        chk(n, c * 8);
        rd(8'h00, 2'h0);
        chk(v, 32'h1);
        wr(8'h04, 32'h0, 2'h0);
        wr(8'h00, 32'h1, 2'h0);
        repeat (c * 8 + 8) @(posedge REF_CLK);
        chk(IRQ, 32'h0);
        rd(8'h00, 2'h0);
        chk(v, 32'h1);
        wr(8'h54, 32'h0c, 2'h0);
        rd(8'h08, 2'h0);
        chk(v, 32'h0);
        $display("timer done");
        wr(8'h64, 32'h3, 2'h0);
        wr(8'h00, 32'h3, 2'h0);
        wr(8'h04, 32'h1, 2'h0);
        go(8'h1c);
        for (i = 1; i < 4; i++) begin
            EVENT_IN <= 1'b1;
            repeat (8) @(posedge REF_CLK);
            chk(IRQ, 32'h0);
            EVENT_IN <= 1'b0;
            repeat (8) @(posedge REF_CLK);
            chk(IRQ, i == 3);
        end
        wr(8'h54, 32'h1c, 2'h0);
        $display("events done");
        wr(8'h64, 32'h1, 2'h0);
        go(8'h0a);
        repeat (20) @(posedge REF_CLK);
        STOP_ENTRY <= 1'b1;
        @(posedge REF_CLK);
        STOP_ENTRY <= 1'b0;
        rd(8'h54, 2'h0);
        chk(v & 32'h3f, 32'h0a);
        chk(DIVIDER_OUT, 32'h1);
        $display("stop entry done");
        results();
    end
endmodule
